// ### nav_pkg.sv
/*
  Shared constants and types for the front-panel button navigator.
  Assumes a single 125 MHz system clock; times here are in ms, except TICK_CYCLES, in clock cycles.
*/
package nav_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / MS_PER_S;

  // ----------------------------------------------------------------
  // Press and refresh timing, in milliseconds
  // ----------------------------------------------------------------
  localparam int DEBOUNCE_MS      = 20;
  localparam int LONG_MIN_MS      = 1000;
  localparam int LONG_MAX_MS      = 2000;
  localparam int EXT_MIN_MS       = 5000;
  localparam int REFRESH_MS       = 1000;
  localparam int REFRESH_CLOCK_MS = 500;

  localparam int HOLD_W    = 13;
  localparam int REFRESH_W = 10;

  localparam logic [HOLD_W-1:0] HOLD_ZERO     = '0;
  localparam logic [HOLD_W-1:0] HOLD_LONG_MIN = HOLD_W'(LONG_MIN_MS);
  localparam logic [HOLD_W-1:0] HOLD_LONG_MAX = HOLD_W'(LONG_MAX_MS);
  localparam logic [HOLD_W-1:0] HOLD_EXT_MIN  = HOLD_W'(EXT_MIN_MS);
  localparam logic [HOLD_W-1:0] HOLD_ONE      = HOLD_W'(1);

  localparam logic [REFRESH_W-1:0] REFRESH_ZERO = '0;
  localparam logic [REFRESH_W-1:0] REFRESH_LAST =
    REFRESH_W'(REFRESH_MS - 1);
  localparam logic [REFRESH_W-1:0] REFRESH_CLOCK_LAST =
    REFRESH_W'(REFRESH_CLOCK_MS - 1);
  localparam logic [REFRESH_W-1:0] REFRESH_ONE = REFRESH_W'(1);

  // ----------------------------------------------------------------
  // Modes, press classes and action pulses
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MODE_DATA = 1'b0,
    MODE_PROG = 1'b1
  } mode_e;

  typedef enum logic [1:0] {
    PRESS_NONE  = 2'b00,
    PRESS_SHORT = 2'b01,
    PRESS_LONG  = 2'b10,
    PRESS_EXT   = 2'b11
  } press_e;

  typedef struct packed {
    logic page_next;
    logic view_next;
    logic page_home;
    logic enter_prog;
    logic shortcut;
    logic menu_step;
    logic digit_change;
    logic menu_move;
    logic menu_select;
    logic reset_cmd;
  } nav_action_s;

  localparam nav_action_s ACTION_NONE = '0;

endpackage

// ### button_debounce.sv
/*
  One push-button input: two-flop synchroniser then a debouncer.
  Assumes a one-cycle millisecond tick from the same clock domain.
*/
module button_debounce
  import nav_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = DEBOUNCE_MS
)(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic tick_i,
  input  wire logic raw_i,
  output logic      level_o
);

  localparam int CNT_W = $clog2(DEBOUNCE_TICKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_TICKS - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  if (DEBOUNCE_TICKS < 1)
  begin
    $error("DEBOUNCE_TICKS must be at least 1");
  end

  typedef struct packed {
    logic             meta;
    logic             sync;
    logic             level;
    logic [CNT_W-1:0] cnt;
  } deb_state_s;

  deb_state_s state;
  deb_state_s next_state;

  // ----------------------------------------------------------------
  // Settle filter: level follows only after a stable run
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_state.meta = raw_i;
    next_state.sync = state.meta;
    if (state.sync == state.level)
    begin
      next_state.cnt = '0;
    end
    else if (tick_i)
    begin
      if (state.cnt == CNT_LAST)
      begin
        next_state.level = state.sync;
        next_state.cnt   = '0;
      end
      else
      begin
        next_state.cnt = state.cnt + CNT_ONE;
      end
    end
  end

  // Released buttons read as zero after reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign level_o = state.level;

endmodule

// ### front_panel_button_navigator.sv
/*
  Front-panel navigator: two unlabelled buttons, press classing,
  mode-dependent action pulses and display refresh pacing.
  Assumes active-high button pins, asynchronous to clk_i, and a menu
  engine outside that reports numeric entry, reset items and exits.
*/

module front_panel_button_navigator
  import nav_pkg::*;
#(
  parameter int TICK_CYCLES_P  = TICK_CYCLES,
  parameter int DEBOUNCE_TICKS = DEBOUNCE_MS
)(
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  input  wire logic  scroll_btn_i,
  input  wire logic  select_btn_i,
  input  wire logic  digit_entry_i,
  input  wire logic  reset_item_i,
  input  wire logic  shortcut_page_i,
  input  wire logic  clock_page_i,
  input  wire logic  exit_prog_i,
  output mode_e      mode_o,
  output press_e     press_class_o,
  output logic       press_valid_o,
  output nav_action_s action_o,
  output logic       refresh_o
);

  localparam int PRE_W = $clog2(TICK_CYCLES_P);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES_P - 1);
  localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);

  if (TICK_CYCLES_P < 2)
  begin
    $error("TICK_CYCLES_P must be at least 2");
  end

  typedef struct packed {
    mode_e                mode;
    logic [PRE_W-1:0]     pre;
    logic [HOLD_W-1:0]    hold;
    logic [REFRESH_W-1:0] refresh_cnt;
    logic                 scroll_q;
    logic                 select_q;
    logic                 combo;
    logic                 consumed;
    press_e               press_class;
    logic                 press_valid;
    nav_action_s          action;
    logic                 refresh;
  } nav_state_s;

  nav_state_s state;
  nav_state_s next_state;

  logic tick;
  logic scroll_lvl;
  logic select_lvl;

  // Hold time in ms to press class; 2 to 5 s is no class
  function automatic press_e classify(input logic [HOLD_W-1:0] held);
    if (held < HOLD_LONG_MIN)
      classify = PRESS_SHORT;
    else if (held <= HOLD_LONG_MAX)
      classify = PRESS_LONG;
    else if (held >= HOLD_EXT_MIN)
      classify = PRESS_EXT;
    else
      classify = PRESS_NONE;
  endfunction

  // ----------------------------------------------------------------
  // Button conditioning
  // ----------------------------------------------------------------
  assign tick = (state.pre == PRE_LAST);

  button_debounce #(
    .DEBOUNCE_TICKS (DEBOUNCE_TICKS)
  ) u_scroll_deb (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick),
    .raw_i   (scroll_btn_i),
    .level_o (scroll_lvl)
  );

  button_debounce #(
    .DEBOUNCE_TICKS (DEBOUNCE_TICKS)
  ) u_select_deb (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick),
    .raw_i   (select_btn_i),
    .level_o (select_lvl)
  );

  // ----------------------------------------------------------------
  // Navigation decisions
  // ----------------------------------------------------------------
  always_comb
  begin
    logic scroll_rise;
    logic select_rise;
    logic select_fall;
    press_e cls;
    scroll_rise = scroll_lvl & ~state.scroll_q;
    select_rise = select_lvl & ~state.select_q;
    select_fall = ~select_lvl & state.select_q;
    cls         = classify(state.hold);

    next_state             = state;
    next_state.scroll_q    = scroll_lvl;
    next_state.select_q    = select_lvl;
    next_state.action      = ACTION_NONE;
    next_state.press_valid = 1'b0;
    next_state.refresh     = 1'b0;
    next_state.pre         = tick ? '0 : state.pre + PRE_ONE;

    // Hold timer saturates so a stuck button cannot wrap it
    if (select_rise)
    begin
      next_state.hold     = HOLD_ZERO;
      next_state.consumed = 1'b0;
    end
    else if (select_lvl && tick && state.hold != HOLD_EXT_MIN)
    begin
      next_state.hold = state.hold + HOLD_ONE;
    end

    // Both buttons down together marks a combined press
    if ((select_rise && scroll_lvl) || (scroll_rise && select_lvl))
    begin
      next_state.combo = 1'b1;
    end

    // Scroll fires on the press edge, not on release
    if (scroll_rise && !select_lvl)
    begin
      if (state.mode == MODE_DATA)
        next_state.action.page_next = 1'b1;
      else if (digit_entry_i)
        next_state.action.digit_change = 1'b1;
      else
        next_state.action.menu_step = 1'b1;
    end

    // Extended hold acts the moment 5 s is reached; a fresh press
    // must not inherit a stale count left by the previous release
    if (select_lvl && state.select_q && tick && !state.consumed &&
        state.hold == HOLD_EXT_MIN - HOLD_ONE)
    begin
      next_state.consumed    = 1'b1;
      next_state.press_class = PRESS_EXT;
      if (state.mode == MODE_DATA)
      begin
        if (state.combo)
        begin
          if (shortcut_page_i)
          begin
            next_state.action.shortcut = 1'b1;
            next_state.mode = MODE_PROG;
          end
        end
        else
        begin
          next_state.action.enter_prog = 1'b1;
          next_state.mode = MODE_PROG;
        end
      end
    end

    // Select decides on release, by how long it was held
    if (select_fall && !state.consumed)
    begin
      next_state.press_class = cls;
      next_state.press_valid = 1'b1;
      if (state.combo)
      begin
        if (state.mode == MODE_DATA && cls == PRESS_SHORT)
          next_state.action.page_home = 1'b1;
      end
      else if (state.mode == MODE_DATA)
      begin
        if (cls == PRESS_SHORT)
          next_state.action.view_next = 1'b1;
      end
      else if (cls == PRESS_SHORT)
      begin
        next_state.action.menu_move = 1'b1;
      end
      else
      begin
        next_state.action.menu_select = 1'b1;
        next_state.action.reset_cmd = reset_item_i;
      end
    end

    if (!select_lvl && !scroll_lvl)
    begin
      next_state.combo = 1'b0;
    end

    // Menu engine hands control back to data viewing
    if (exit_prog_i && state.mode == MODE_PROG)
    begin
      next_state.mode = MODE_DATA;
    end

    // Refresh pacing; clock page runs at double rate
    if (tick)
    begin
      if (state.refresh_cnt >=
          (clock_page_i ? REFRESH_CLOCK_LAST : REFRESH_LAST))
      begin
        next_state.refresh_cnt = REFRESH_ZERO;
        next_state.refresh     = 1'b1;
      end
      else
      begin
        next_state.refresh_cnt = state.refresh_cnt + REFRESH_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state             <= '0;
      state.mode        <= MODE_DATA;
      state.press_class <= PRESS_NONE;
      state.action      <= ACTION_NONE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign mode_o        = state.mode;
  assign press_class_o = state.press_class;
  assign press_valid_o = state.press_valid;
  assign action_o      = state.action;
  assign refresh_o     = state.refresh;

endmodule

// ### nav_chk.sv
/*
  Port checker for the front-panel button navigator.
  Assumes binding to the top with the same tick parameter.
*/
module nav_chk
  import nav_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)(
  input logic        clk_i,
  input logic        rst_b_i,
  input logic        scroll_btn_i,
  input logic        select_btn_i,
  input logic        digit_entry_i,
  input logic        reset_item_i,
  input logic        exit_prog_i,
  input mode_e       mode_o,
  input press_e      press_class_o,
  input logic        press_valid_o,
  input nav_action_s action_o,
  input logic        refresh_o
);
  localparam int RMAX = 1000 * TICK_CYCLES_P + 4;
  int gap;

  // Cycles since last refresh; slack covers the tick phase
  always_ff @(posedge clk_i)
  begin
    gap <= (!rst_b_i || refresh_o) ? 0 : gap + 1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_prog_entered;
    (action_o.enter_prog || action_o.shortcut) && mode_o == MODE_PROG;
  endsequence

  property p_reset;
    disable iff (1'b0) !rst_b_i |=> mode_o == MODE_DATA &&
      action_o == ACTION_NONE && press_class_o == PRESS_NONE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_scroll;
    action_o.page_next |-> $past(scroll_btn_i, 4) && mode_o == MODE_DATA;
  endproperty
  a_scroll: assert property (p_scroll) else $error("page step");
  property p_release;
    press_valid_o |-> !$past(select_btn_i, 4);
  endproperty
  a_release: assert property (p_release) else $error("release");
  property p_view;
    action_o.view_next |-> press_valid_o && press_class_o == PRESS_SHORT
      && mode_o == MODE_DATA;
  endproperty
  a_view: assert property (p_view) else $error("view step");
  property p_enter;
    $rose(mode_o) |-> s_prog_entered;
  endproperty
  a_enter: assert property (p_enter) else $error("mode entry");
  property p_exit;
    $fell(mode_o) |-> $past(exit_prog_i);
  endproperty
  a_exit: assert property (p_exit) else $error("mode exit");
  property p_digit;
    action_o.digit_change |-> $past(digit_entry_i) && mode_o == MODE_PROG
      && !action_o.menu_step;
  endproperty
  a_digit: assert property (p_digit) else $error("digit");
  property p_select;
    action_o.menu_select |-> press_valid_o && mode_o == MODE_PROG &&
      press_class_o != PRESS_SHORT;
  endproperty
  a_select: assert property (p_select) else $error("select");
  property p_rstcmd;
    action_o.reset_cmd |-> action_o.menu_select && $past(reset_item_i);
  endproperty
  a_rstcmd: assert property (p_rstcmd) else $error("reset cmd");
  property p_refresh;
    gap <= RMAX;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh");
endmodule

bind front_panel_button_navigator nav_chk #(
  .TICK_CYCLES_P(TICK_CYCLES_P)
) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .scroll_btn_i(scroll_btn_i),
  .select_btn_i(select_btn_i), .digit_entry_i(digit_entry_i),
  .reset_item_i(reset_item_i), .exit_prog_i(exit_prog_i),
  .mode_o(mode_o), .press_class_o(press_class_o),
  .press_valid_o(press_valid_o), .action_o(action_o),
  .refresh_o(refresh_o)
);

// ### nav_operator.sv
/*
  Operator model: presses the two buttons for a given hold.
  Assumes pins read high when pressed and low when released.
*/
module nav_operator (
  input  wire logic clk_i,
  output logic      scroll_o,
  output logic      select_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scroll_o = 1'b0;
    select_o = 1'b0;
  end

  // Contact bounce first, shorter than the debounce window
  task automatic press(input logic [1:0] b, input int cyc);
    repeat (3)
    begin
      @(posedge clk_i);
      {scroll_o, select_o} <= b;
      @(posedge clk_i);
      {scroll_o, select_o} <= 2'b00;
    end
    @(posedge clk_i);
    {scroll_o, select_o} <= b;
    repeat (cyc) @(posedge clk_i);
    {scroll_o, select_o} <= 2'b00;
  endtask
endmodule

// ### front_panel_button_navigator_tb.sv
/*
  Self-checking bench for the button navigator.
  Assumes a shortened ms tick; holds stay in ms ticks.
*/
module front_panel_button_navigator_tb;
  import nav_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TK = 2;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, scroll_w, select_w;
  logic        digit_entry_i = 1'b0, reset_item_i = 1'b0;
  logic        shortcut_page_i = 1'b0, clock_page_i = 1'b0;
  logic        exit_prog_i = 1'b0, press_valid_o, refresh_o;
  mode_e       mode_o, m;
  press_e      press_class_o;
  nav_action_s action_o, seen;
  int          pv_n, err_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] st = 32'h00018438; // 99384
  logic [31:0] r;

  always #4 clk_i = ~clk_i;

  front_panel_button_navigator #(.TICK_CYCLES_P(TK), .DEBOUNCE_TICKS(2))
  uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scroll_btn_i(scroll_w),
    .select_btn_i(select_w), .digit_entry_i(digit_entry_i),
    .reset_item_i(reset_item_i), .shortcut_page_i(shortcut_page_i),
    .clock_page_i(clock_page_i), .exit_prog_i(exit_prog_i),
    .mode_o(mode_o), .press_class_o(press_class_o),
    .press_valid_o(press_valid_o), .action_o(action_o),
    .refresh_o(refresh_o)
  );
  nav_operator op (.clk_i(clk_i), .scroll_o(scroll_w), .select_o(select_w));

  // Pulse collector on the falling edge, where outputs have settled
  always @(negedge clk_i)
  begin
    seen <= seen | action_o;
    if (press_valid_o) pv_n <= pv_n + 1;
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      err_count++;
      give_verdict();
    end
  end

  function logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  function nav_action_s exp_act(logic [1:0] b, int ms);
    nav_action_s a;
    a = ACTION_NONE;
    if (b == 2'b10 && m == MODE_DATA) a.page_next = 1'b1;
    else if (b == 2'b10)
    begin
      a.digit_change = digit_entry_i;
      a.menu_step = !digit_entry_i;
    end
    else if (b == 2'b01 && m == MODE_DATA)
    begin
      a.view_next = ms < 1000;
      a.enter_prog = ms >= 5000;
    end
    else if (b == 2'b01)
    begin
      a.menu_move = ms < 1000;
      a.menu_select = ms >= 1000 && ms < 5000;
      a.reset_cmd = a.menu_select && reset_item_i;
    end
    else if (m == MODE_DATA)
    begin
      a.page_home = ms < 1000;
      a.shortcut = ms >= 5000 && shortcut_page_i;
    end
    return a;
  endfunction

  function press_e exp_cls(int ms);
    if (ms < 1000)
      return PRESS_SHORT;
    if (ms <= 2000)
      return PRESS_LONG;
    if (ms >= 5000)
      return PRESS_EXT;
    return PRESS_NONE;
  endfunction

  task chk_act(nav_action_s g, nav_action_s e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task chk_val(logic [15:0] g, logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task do_press(logic [1:0] b, int ms);
    nav_action_s e;
    @(posedge clk_i);
    e = exp_act(b, ms);
    seen = ACTION_NONE;
    pv_n = 0;
    op.press(b, ms * TK);
    repeat (80) @(posedge clk_i);
    chk_act(seen, e);
    if (b == 2'b01) chk_val(16'(pv_n), 16'(ms < 5000));
    if (b == 2'b01)
      chk_val(16'(press_class_o), 16'(exp_cls(ms)));
    if (e.enter_prog || e.shortcut) m = MODE_PROG;
    chk_val(16'(mode_o), 16'(m));
  endtask

  task meas(logic cp, int exp);
    int n;
    @(posedge clk_i);
    clock_page_i <= cp;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(negedge clk_i);
        n++;
      end while (!refresh_o && n < 9000);
    end
    chk_val(16'(n), 16'(exp));
  endtask

  task leave_prog();
    @(posedge clk_i);
    exit_prog_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    exit_prog_i <= 1'b0;
    m = MODE_DATA;
    repeat (4) @(posedge clk_i);
    chk_val(16'(mode_o), 16'(m));
  endtask

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    m = MODE_DATA;
    seen = ACTION_NONE;
    pv_n = 0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_val(16'(mode_o), 16'(MODE_DATA));
    chk_val(16'(press_class_o), 16'(PRESS_NONE));
    $display("test reset done");
    do_press(2'b10, 30);
    do_press(2'b01, 40);
    do_press(2'b11, 60);
    do_press(2'b01, 1900);
    repeat (5)
    begin
      r = rnd();
      do_press(r[1:0] == 2'b00 ? 2'b10 : r[1:0],
               (r[20:10] % 1700) inside {[960:1040]} ? 1100 :
               20 + int'(r[20:10] % 1700));
    end
    $display("test data mode done");
    meas(1'b1, 500 * TK);
    meas(1'b0, 1000 * TK);
    $display("test refresh done");
    do_press(2'b01, 5100);
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      @(posedge clk_i);
      digit_entry_i <= i[0];
      reset_item_i <= i[0];
      do_press(i[1] ? 2'b01 : 2'b10, i[0] ? 1300 : 20 + int'(r[8:0]));
    end
    leave_prog();
    $display("test programming done");
    @(posedge clk_i);
    shortcut_page_i <= 1'b1;
    do_press(2'b11, 5100);
    leave_prog();
    $display("test shortcut done");
    give_verdict();
  end
endmodule
